// >>> design/rag_pkg.sv
// Shared constants, types and helpers for rotor alignment and bus overvoltage guard.
package rag_pkg;

  // Core clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 10;

  // Width of a sensing pulse in ns; a least time, so the cycle count rounds up.
  localparam int PULSE_TIME_NS = 20000;
  localparam int PULSE_CYCLES = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Current decay gap after each pulse in ns; also a least time.
  localparam int DECAY_TIME_NS = 30000;
  localparam int DECAY_CYCLES = (DECAY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Width of current and bus voltage samples.
  localparam int SAMPLE_W = 12;

  // Width of the pulse and gap timer.
  localparam int TIMER_W = 16;

  // Gate drive for the three legs, bit 0 is phase U, bit 1 V, bit 2 W.
  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } rag_gate_t;

  // All switches open; the reset value of the gate outputs.
  localparam rag_gate_t GATE_OFF = '{high: 3'h0, low: 3'h0};

  // Zero vector: every low-side switch on, every high-side switch off.
  localparam rag_gate_t GATE_ZERO_VECTOR = '{high: 3'h0, low: 3'h7};

  // Sector code reported when the polarity pattern is not a legal one.
  localparam logic [2:0] SECTOR_NONE = 3'h7;

  // Alignment result and progress as seen by the control logic.
  typedef struct packed {
    logic busy;
    logic done;
    logic valid;
    logic [2:0] polarity;
    logic [2:0] sector;
  } rag_align_status_t;

  // Reset value of the alignment status.
  localparam rag_align_status_t STATUS_RESET = '{
    busy: 1'b0, done: 1'b0, valid: 1'b0, polarity: 3'h0, sector: 3'h7};

  // Alignment sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FWD,
    ST_GAP_FWD,
    ST_REV,
    ST_GAP_REV
  } rag_state_t;

  // Maps the three half-turn polarity results onto a sixty-degree sector index.
  function automatic logic [2:0] sector_of(input logic [2:0] pol);
    logic [2:0] sec;
    sec = SECTOR_NONE;
    case (pol)
      3'h1: sec = 3'h0;
      3'h3: sec = 3'h1;
      3'h2: sec = 3'h2;
      3'h6: sec = 3'h3;
      3'h4: sec = 3'h4;
      3'h5: sec = 3'h5;
      default: sec = SECTOR_NONE;
    endcase
    return sec;
  endfunction

endpackage

// >>> design/rag_peak_hold.sv
// Peak detector that holds the largest current sample seen since its last clear.
`timescale 1ns/1ps
`default_nettype none
module rag_peak_hold #(
  parameter int W = 12
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clear,
  input wire logic sampleEn,
  input wire logic [W-1:0] sample,
  output logic [W-1:0] peak
);

  // A clear restarts the hold at zero; the sample in that cycle still counts.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      peak <= '0;
    end else if (clear) begin
      peak <= sampleEn ? sample : '0;
    end else if (sampleEn && (sample > peak)) begin
      peak <= sample;
    end
  end

endmodule
`default_nettype wire

// >>> design/rag_rotor_align_guard.sv
// Inverter gate control with start-up rotor alignment sensing and overvoltage zero vector.
//
// Summary of operation
// - Each sensing pulse applies bus voltage for one fixed, preset time.
// - Forward pulse: selected leg high, other two legs low.
// - Opposing pulse follows on the same winding: two legs high, selected leg low.
// - Capture the peak current of both pulses and compare them.
// - Larger peak marks the magnet polarity, giving position within half a turn.
// - Repeat for the other two phases and combine into a sixty-degree sector.
// - Flag critical overvoltage when bus voltage exceeds the configurable threshold.
// - Overvoltage forces the zero vector, all low sides on, above every fault.
// - Hold the zero vector while the overvoltage fault stays set.
`timescale 1ns/1ps
`default_nettype none
module rag_rotor_align_guard #(
  parameter int PULSE_CYC = rag_pkg::PULSE_CYCLES,
  parameter int DECAY_CYC = rag_pkg::DECAY_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic alignStart,
  input wire logic [rag_pkg::SAMPLE_W-1:0] currentSample,
  input wire logic currentValid,
  input wire logic [rag_pkg::SAMPLE_W-1:0] busVoltage,
  input wire logic [rag_pkg::SAMPLE_W-1:0] ovThreshold,
  input wire logic ovClear,
  input wire logic faultActive,
  input wire rag_pkg::rag_gate_t pwmRequest,
  output rag_pkg::rag_gate_t gate,
  output rag_pkg::rag_align_status_t alignStatus,
  output logic criticalBusOvervoltage
);
  import rag_pkg::*;

  localparam logic [TIMER_W-1:0] PULSE_LAST = TIMER_W'(PULSE_CYC - 1);
  localparam logic [TIMER_W-1:0] DECAY_LAST = TIMER_W'(DECAY_CYC - 1);

  rag_state_t state;
  logic [TIMER_W-1:0] timer;
  logic [1:0] phase;
  logic [2:0] polarity;
  logic [SAMPLE_W-1:0] fwdPeak;
  logic [SAMPLE_W-1:0] peak;
  logic peakClear;
  logic pulseOn;
  logic overVoltage;
  logic timerDone;
  logic [2:0] phaseMask;
  rag_gate_t alignGate;
  rag_gate_t next_gate;

  // Bus voltage comparison; samples arrive from converter logic on this clock.
  assign overVoltage = busVoltage > ovThreshold;

  // The timer ends the current pulse or gap at its fixed preset length.
  assign timerDone = ((state == ST_FWD) || (state == ST_REV)) ? (timer == PULSE_LAST)
                                                              : (timer == DECAY_LAST);
  assign phaseMask = 3'h1 << phase;
  assign pulseOn = (state == ST_FWD) || (state == ST_REV);

  // Hold the peak at zero outside every pulse, gaps after opposing pulses included.
  // Without the clear in the last gap an opposing peak would leak into the next phase.
  assign peakClear = !pulseOn;

  // Only samples taken while voltage is applied feed the peak.
  rag_peak_hold #(
    .W(SAMPLE_W)
  ) uPeak (
    .clk(clk),
    .rstn(rstn),
    .clear(peakClear),
    .sampleEn(pulseOn && currentValid),
    .sample(currentSample),
    .peak(peak)
  );

  // Sticky overvoltage flag; a new excess in the clear cycle keeps it set.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      criticalBusOvervoltage <= 1'b0;
    end else if (overVoltage) begin
      criticalBusOvervoltage <= 1'b1;
    end else if (ovClear) begin
      criticalBusOvervoltage <= 1'b0;
    end
  end

  // Alignment sequencer: forward pulse, gap, opposing pulse, gap, for each phase.
  // An overvoltage aborts the sequence, since the zero vector would spoil the peaks.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= ST_IDLE;
      timer <= '0;
      phase <= 2'h0;
    end else if (criticalBusOvervoltage || overVoltage) begin
      state <= ST_IDLE;
      timer <= '0;
      phase <= 2'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          timer <= '0;
          phase <= 2'h0;
          if (alignStart && !faultActive) begin
            state <= ST_FWD;
          end
        end
        ST_FWD: begin
          timer <= timerDone ? '0 : timer + 1'b1;
          if (timerDone) begin
            state <= ST_GAP_FWD;
          end
        end
        ST_GAP_FWD: begin
          timer <= timerDone ? '0 : timer + 1'b1;
          if (timerDone) begin
            state <= ST_REV;
          end
        end
        ST_REV: begin
          timer <= timerDone ? '0 : timer + 1'b1;
          if (timerDone) begin
            state <= ST_GAP_REV;
          end
        end
        ST_GAP_REV: begin
          timer <= timerDone ? '0 : timer + 1'b1;
          if (timerDone) begin
            phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
            state <= (phase == 2'h2) ? ST_IDLE : ST_FWD;
          end
        end
      endcase
    end
  end

  // Keep the forward peak and decide polarity once the opposing peak is known.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      fwdPeak <= '0;
      polarity <= 3'h0;
    end else begin
      if ((state == ST_FWD) && timerDone) begin
        fwdPeak <= peak;
      end
      if ((state == ST_REV) && timerDone) begin
        polarity[phase] <= fwdPeak > peak;
      end
    end
  end

  // Result register; the sector is only published after all three phases.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      alignStatus <= STATUS_RESET;
    end else begin
      alignStatus.busy <= (state != ST_IDLE) && !criticalBusOvervoltage && !overVoltage;
      alignStatus.done <= 1'b0;
      if ((state == ST_IDLE) && alignStart && !faultActive) begin
        alignStatus.valid <= 1'b0;
      end
      if ((state == ST_GAP_REV) && timerDone && (phase == 2'h2) && !criticalBusOvervoltage
          && !overVoltage) begin
        alignStatus.done <= 1'b1;
        alignStatus.valid <= sector_of(polarity) != SECTOR_NONE;
        alignStatus.polarity <= polarity;
        alignStatus.sector <= sector_of(polarity);
      end
    end
  end

  // Sensing pulse patterns; gaps leave every switch open so the current decays.
  always_comb begin
    alignGate = GATE_OFF;
    if (state == ST_FWD) begin
      alignGate.high = phaseMask;
      alignGate.low = ~phaseMask;
    end else if (state == ST_REV) begin
      alignGate.high = ~phaseMask;
      alignGate.low = phaseMask;
    end
  end

  // Output priority: overvoltage, then faults, then alignment, then normal PWM.
  // A requested pair with both sides on is resolved to the low side.
  always_comb begin
    next_gate = GATE_OFF;
    if (criticalBusOvervoltage || overVoltage) begin
      next_gate = GATE_ZERO_VECTOR;
    end else if (faultActive) begin
      next_gate = GATE_OFF;
    end else if (state != ST_IDLE) begin
      next_gate = alignGate;
    end else begin
      next_gate.low = pwmRequest.low;
      next_gate.high = pwmRequest.high & ~pwmRequest.low;
    end
  end

  // Gate drive comes straight from a flip-flop to avoid glitches on the driver inputs.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      gate <= GATE_OFF;
    end else begin
      gate <= next_gate;
    end
  end

  // Checks kept beside the logic they guard.
  a_ov_sets_flag: assert property (@(posedge clk) disable iff (!rstn)
    (busVoltage > ovThreshold) |=> criticalBusOvervoltage)
    else $error("overvoltage flag not set");

  a_ov_zero_vector: assert property (@(posedge clk) disable iff (!rstn)
    (criticalBusOvervoltage && faultActive) |=> (gate == GATE_ZERO_VECTOR))
    else $error("zero vector not forced");

  a_ov_hold_state: assert property (@(posedge clk) disable iff (!rstn)
    (criticalBusOvervoltage && !ovClear) |=> criticalBusOvervoltage
      ##1 (gate == GATE_ZERO_VECTOR))
    else $error("overvoltage hold lost");

  a_leg_exclusive: assert property (@(posedge clk) disable iff (!rstn)
    (gate.high & gate.low) == 3'h0)
    else $error("both switches of a leg on");

  a_pulse_length: assert property (@(posedge clk) disable iff (!rstn)
    (state == ST_FWD) |-> (timer <= PULSE_LAST))
    else $error("sensing pulse too long");

  a_fwd_pattern: assert property (@(posedge clk) disable iff (!rstn)
    ((state == ST_FWD) && !faultActive && !overVoltage && !criticalBusOvervoltage)
      |=> (gate.high == $past(phaseMask)) && (gate.low == ~$past(phaseMask)))
    else $error("forward pattern wrong");

  a_rev_follows: assert property (@(posedge clk) disable iff (!rstn)
    ((state == ST_GAP_FWD) && timerDone && !overVoltage && !criticalBusOvervoltage)
      |=> (state == ST_REV) && (phase == $past(phase)))
    else $error("opposing pulse missing");

  a_polarity_pick: assert property (@(posedge clk) disable iff (!rstn)
    ((state == ST_REV) && timerDone && !overVoltage && !criticalBusOvervoltage)
      |=> (polarity[$past(phase)] == ($past(fwdPeak) > $past(peak))))
    else $error("polarity decision wrong");

  a_sector_result: assert property (@(posedge clk) disable iff (!rstn)
    alignStatus.done |-> (alignStatus.sector == sector_of(alignStatus.polarity)))
    else $error("sector does not match polarity");

endmodule
`default_nettype wire

// >>> verification/rag_inverter_model.sv
// Behavioural inverter leg set and motor winding answering gate drive with a current ramp.
`timescale 1ns/1ps
`default_nettype none
module rag_inverter_model
  import rag_pkg::*;
(
  input wire logic clk,
  input wire rag_pkg::rag_gate_t gate,
  input wire logic [2:0] magnetPol,
  output logic [rag_pkg::SAMPLE_W-1:0] currentSample,
  output logic currentValid
);
  logic [7:0] ramp = 8'h00;
  logic [7:0] tick = 8'h00;
  logic aligned;
  logic [3:0] legGain;

  // A pulse along the magnet saturates the core, so its current climbs faster.
  // Each winding has its own gain, so a peak carried from one phase into the next shows up.
  always_comb begin
    aligned = 1'b0;
    legGain = 4'h0;
    for (int p = 0; p < 3; p++) begin
      if (gate.high == (3'h1 << p)) begin
        aligned = magnetPol[p];
        legGain = 4'(3 - p);
      end
      if (gate.high == ~(3'h1 << p)) begin
        aligned = ~magnetPol[p];
        legGain = 4'(3 - p);
      end
    end
  end

  // The ramp restarts with every pulse; the free tick scrambles the idle sense line.
  always_ff @(posedge clk) begin
    tick <= tick + 8'h01;
    ramp <= (|gate.high) ? ramp + 8'h01 : 8'h00;
  end

  // Outside a pulse the sample is noise, so nothing may rely on its last value.
  assign currentValid = |gate.high;
  assign currentSample = currentValid ? {4'h0, ramp} * {8'h00, legGain} *
                                        (aligned ? 12'h003 : 12'h002)
                                      : {tick, 4'ha};
endmodule
`default_nettype wire

// >>> verification/test_rag_rotor_align_guard.sv
// Self-checking bench for the rotor alignment and overvoltage gate controller.
`timescale 1ns/1ps
`default_nettype none
module test_rag_rotor_align_guard;
  import rag_pkg::*;
  localparam int PC = 4;
  localparam int DC = 3;
  localparam logic [11:0] THR = 12'h800;
  logic clk, rstn, alignStart, currentValid, ovClear, faultActive, critOv, seen;
  logic [SAMPLE_W-1:0] currentSample, busVoltage, ovThreshold;
  logic [2:0] magnetPol;
  rag_gate_t pwmRequest, gate;
  rag_align_status_t alignStatus;
  int mismatches, cmpCount, n;
  // Rows: magnet polarity (the index) beside the expected {valid, sector}.
  logic [3:0] expRow [8] = '{4'h7, 4'h8, 4'ha, 4'h9, 4'hc, 4'hd, 4'hb, 4'h7};

  rag_rotor_align_guard #(.PULSE_CYC(PC), .DECAY_CYC(DC)) dut (.clk(clk), .rstn(rstn),
    .alignStart(alignStart), .currentSample(currentSample), .currentValid(currentValid),
    .busVoltage(busVoltage), .ovThreshold(ovThreshold), .ovClear(ovClear),
    .faultActive(faultActive), .pwmRequest(pwmRequest), .gate(gate),
    .alignStatus(alignStatus), .criticalBusOvervoltage(critOv));
  rag_inverter_model model (.clk(clk), .gate(gate), .magnetPol(magnetPol),
    .currentSample(currentSample), .currentValid(currentValid));

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("Mismatches %0d, comparisons %0d", mismatches, cmpCount);
    if (mismatches == 0 && cmpCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Compare tasks, one for each kind of result.
  task automatic chk_gate(input rag_gate_t got, input rag_gate_t exp);
    cmpCount++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t gate got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_field(input logic [3:0] got, input logic [3:0] exp);
    cmpCount++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t field got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    cmpCount++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t bit got %h exp %h", $time, got, exp);
    end
  endtask

  // Inputs move only at falling edges so the design samples settled values.
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic start_align();
    alignStart = 1'b1;
    cyc(1);
    alignStart = 1'b0;
  endtask
  // Bounded watch for the done pulse; cnt counts clock edges after the call, up to 80.
  task automatic wait_done(output logic s, output int cnt);
    s = 1'b0;
    cnt = 0;
    for (int i = 0; i < 80 && !s; i++) begin
      cyc(1);
      cnt = i + 1;
      if (alignStatus.done === 1'b1) s = 1'b1;
    end
  endtask

  initial begin
    rstn = 1'b0;
    alignStart = 1'b0;
    ovClear = 1'b0;
    faultActive = 1'b0;
    busVoltage = 12'h100;
    ovThreshold = THR;
    pwmRequest = GATE_OFF;
    magnetPol = 3'h0;
    mismatches = 0;
    cmpCount = 0;
    cyc(8);
    chk_gate(gate, GATE_OFF);
    chk_bit(alignStatus === STATUS_RESET && critOv === 1'b0, 1'b1);
    rstn = 1'b1;
    cyc(1);
    // Every magnet polarity pattern goes through a full alignment.
    for (int r = 0; r < 8; r++) begin
      magnetPol = r[2:0];
      start_align();
      if (r == 1) begin
        cyc(2);
        chk_gate(gate, '{high: 3'h1, low: 3'h6});
        cyc(4);
        chk_gate(gate, GATE_OFF);
        cyc(3);
        chk_gate(gate, '{high: 3'h6, low: 3'h1});
        cyc(4);
        chk_gate(gate, GATE_OFF);
      end
      wait_done(seen, n);
      if (!seen) begin
        mismatches++;
        finish_test();
      end
      if (r == 1) n = n + 13;
      chk_bit(n == 3 * (2 * PC + 2 * DC), 1'b1);
      chk_field({1'b0, alignStatus.polarity}, {1'b0, r[2:0]});
      chk_field({alignStatus.valid, alignStatus.sector}, expRow[r]);
      cyc(1);
    end
    // Overvoltage beats a pending fault and a live request; a clear loses to excess.
    faultActive = 1'b1;
    pwmRequest = '{high: 3'h7, low: 3'h0};
    busVoltage = THR + 12'h001;
    cyc(1);
    chk_bit(critOv, 1'b1);
    chk_gate(gate, GATE_ZERO_VECTOR);
    ovClear = 1'b1;
    cyc(1);
    ovClear = 1'b0;
    cyc(2);
    chk_bit(critOv, 1'b1);
    busVoltage = THR;
    cyc(3);
    chk_gate(gate, GATE_ZERO_VECTOR);
    ovClear = 1'b1;
    cyc(1);
    ovClear = 1'b0;
    chk_bit(critOv, 1'b0);
    chk_gate(gate, GATE_ZERO_VECTOR);
    cyc(2);
    chk_gate(gate, GATE_OFF);
    faultActive = 1'b0;
    pwmRequest = '{high: 3'h5, low: 3'h1};
    cyc(2);
    chk_gate(gate, '{high: 3'h4, low: 3'h1});
    // Overvoltage in mid-sequence abandons the alignment.
    pwmRequest = GATE_OFF;
    start_align();
    cyc(5);
    busVoltage = THR + 12'h001;
    cyc(2);
    chk_gate(gate, GATE_ZERO_VECTOR);
    busVoltage = 12'h100;
    ovClear = 1'b1;
    cyc(1);
    ovClear = 1'b0;
    wait_done(seen, n);
    chk_bit(seen, 1'b0);
    chk_bit(alignStatus.valid, 1'b0);
    // A start while a fault is present is refused.
    faultActive = 1'b1;
    start_align();
    cyc(2);
    chk_bit(alignStatus.busy, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
